// *** include/vok_pkg.sv ***
// Constants shared by the video overlay color key block.
package vok_pkg;
	localparam logic [15:0] IO_INDEX_ADDR = 16'h03c4;
	localparam logic [15:0] IO_DATA_ADDR = 16'h03c5;
	localparam logic [7:0] IDX_CTRL = 8'hd9;
	localparam logic [7:0] IDX_CMP_LO = 8'hda;
	localparam logic [7:0] IDX_CMP_MID = 8'hdb;
	localparam logic [7:0] IDX_CMP_HI = 8'hdc;
	localparam logic [7:0] IDX_MASK_LO = 8'hdd;
	localparam logic [7:0] IDX_MASK_MID = 8'hde;
	localparam logic [7:0] IDX_MASK_HI = 8'hdf;
	localparam int NUM_REGS = 7;
	localparam int CTRL_PORT_EN_BIT = 0;
	localparam int CTRL_WIDE_BIT = 1;
	localparam int CTRL_EXT_KEY_BIT = 2;
	localparam logic [7:0] CTRL_USED_MASK = 8'h07;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam int BYTE_W = 8;
	localparam int PIX_W = 24;
	localparam int CHAN_W = 8;
	localparam int NARROW_CHAN_W = 6;
	localparam int NARROW_W = 18;
	localparam int DATA_BUS_W = 16;
	localparam int STROBE_W = 4;
	localparam int FIFO_W = 25;
	localparam int FIFO_DEPTH = 8;
	localparam int KEY_BIT = 24;
	typedef enum logic [0:0] {
		OS_EMPTY = 1'b0,
		OS_HELD = 1'b1
	} vok_ostate_type;
endpackage

// *** design/vok_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a clear input.
`timescale 1ns/1ns
module vok_fifo #(
	parameter int W = 25,
	parameter int D = 8
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [0:D-1];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (clr) begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (push) begin
				wp_nxt = (wp_r == AW'(D-1)) ? '0 : AW'(wp_r + 1'b1);
			end
			if (pop) begin
				rp_nxt = (rp_r == AW'(D-1)) ? '0 : AW'(rp_r + 1'b1);
			end
			if (push && !pop) begin
				cnt_nxt = (AW+1)'(cnt_r + 1'b1);
			end else if (pop && !push) begin
				cnt_nxt = (AW+1)'(cnt_r - 1'b1);
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage has no reset; only the pointers decide what is valid.
	always_ff @(posedge REF_CLK) begin
		if (push && !clr) begin
			mem_r[wp_r] <= in_data;
		end
	end

	AST_FIFO_NO_OVERFLOW: assert property (@(posedge REF_CLK) disable iff (RST)
		cnt_r <= (AW+1)'(D))
		else $error("FIFO count above depth.");
endmodule // vok_fifo

// *** design/vok_overlay.sv ***
// External video port pin sharing and color-key overlay with its sequencer registers.
`timescale 1ns/1ns
module vok_overlay (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [15:0] IO_ADDR,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA,
	input wire logic [15:0] MEM_C_DATA_BUS_I,
	output logic [15:0] MEM_C_DATA_BUS_O,
	output logic MEM_C_DATA_BUS_OE,
	input wire logic [3:0] MEM_C_STROBES_N_I,
	output logic [3:0] MEM_C_STROBES_N_O,
	output logic MEM_C_STROBES_N_OE,
	input wire logic MEM_C_OUTPUT_ENABLE_N_I,
	output logic MEM_C_OUTPUT_ENABLE_N_O,
	output logic MEM_C_OUTPUT_ENABLE_N_OE,
	input wire logic AUX_ADDRESS_BIT_NINE_I,
	output logic AUX_ADDRESS_BIT_NINE_O,
	output logic AUX_ADDRESS_BIT_NINE_OE,
	input wire logic PANEL_BACKLIGHT_OUT_I,
	output logic PANEL_BACKLIGHT_OUT_O,
	output logic PANEL_BACKLIGHT_OUT_OE,
	input wire logic ACTIVITY_INPUT,
	output logic [7:0] MEM_C_ADDRESS_BUS,
	input wire logic EXT_COLOR_KEY,
	input wire logic VIDEO_IN_STROBE,
	output logic VIDEO_IN_READY,
	input wire logic [15:0] CORE_MEM_DATA_O,
	input wire logic CORE_MEM_DATA_OE,
	output logic [15:0] CORE_MEM_DATA_I,
	input wire logic [3:0] CORE_MEM_STROBES_N,
	input wire logic CORE_MEM_OE_N,
	input wire logic CORE_AUX_ADDR9,
	input wire logic CORE_BACKLIGHT,
	input wire logic [7:0] CORE_MEM_ADDR,
	output logic CORE_ACTIVITY,
	input wire logic BG_VALID,
	output logic BG_READY,
	input wire logic [23:0] BG_PIXEL,
	output logic OUT_VALID,
	input wire logic OUT_READY,
	output logic [23:0] OUT_PIXEL
);
	logic [7:0] regs_r [0:vok_pkg::NUM_REGS-1];
	logic [7:0] regs_nxt [0:vok_pkg::NUM_REGS-1];
	logic [7:0] index_r, index_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic port_en, wide, ext_key;
	logic [23:0] cmp_val, mask_val, vid_pins, vid_pix;
	logic [17:0] narrow_pins;
	logic [24:0] fifo_out;
	logic fifo_valid, fifo_pop, load, match, take_video;
	vok_pkg::vok_ostate_type ostate_r, ostate_nxt;
	logic [23:0] pix_r, pix_nxt;

	// Maps a sequencer index onto a slot of the local register array, or -1.
	function automatic int reg_slot(input logic [7:0] idx);
		if (idx >= vok_pkg::IDX_CTRL && idx <= vok_pkg::IDX_MASK_HI) begin
			return int'(idx - vok_pkg::IDX_CTRL);
		end
		return -1;
	endfunction

	// Register file behind the sequencer index and data ports.
	always_comb begin
		index_nxt = index_r;
		rdata_nxt = rdata_r;
		for (int i = 0; i < vok_pkg::NUM_REGS; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		if (IO_WR && IO_ADDR == vok_pkg::IO_INDEX_ADDR) begin
			index_nxt = IO_WDATA;
		end
		if (IO_WR && IO_ADDR == vok_pkg::IO_DATA_ADDR && reg_slot(index_r) >= 0) begin
			regs_nxt[reg_slot(index_r)] = IO_WDATA;
			if (index_r == vok_pkg::IDX_CTRL) begin
				// Reserved control bits are not stored so they read back as zero.
				regs_nxt[0] = IO_WDATA & vok_pkg::CTRL_USED_MASK;
			end
		end
		if (IO_RD) begin
			if (IO_ADDR == vok_pkg::IO_INDEX_ADDR) begin
				rdata_nxt = index_r;
			end else if (IO_ADDR == vok_pkg::IO_DATA_ADDR && reg_slot(index_r) >= 0) begin
				rdata_nxt = regs_r[reg_slot(index_r)];
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			index_r <= 8'h00;
			rdata_r <= 8'h00;
			regs_r[0] <= vok_pkg::CTRL_RST;
			regs_r[1] <= vok_pkg::CMP_RST;
			regs_r[2] <= vok_pkg::CMP_RST;
			regs_r[3] <= vok_pkg::CMP_RST;
			regs_r[4] <= vok_pkg::MASK_RST;
			regs_r[5] <= vok_pkg::MASK_RST;
			regs_r[6] <= vok_pkg::MASK_RST;
		end else begin
			index_r <= index_nxt;
			rdata_r <= rdata_nxt;
			for (int i = 0; i < vok_pkg::NUM_REGS; i++) begin
				regs_r[i] <= regs_nxt[i];
			end
		end
	end

	assign IO_RDATA = rdata_r;
	assign port_en = regs_r[0][vok_pkg::CTRL_PORT_EN_BIT];
	// Width only counts while the port is on; a stale width bit has no effect.
	assign wide = port_en && regs_r[0][vok_pkg::CTRL_WIDE_BIT];
	assign ext_key = regs_r[0][vok_pkg::CTRL_EXT_KEY_BIT];
	assign cmp_val = {regs_r[3], regs_r[2], regs_r[1]};
	assign mask_val = {regs_r[6], regs_r[5], regs_r[4]};

	// Pin sharing: data and strobe pins only drive while the video port is off; output enable, address bit nine and backlight only outside wide mode.
	assign MEM_C_DATA_BUS_O = CORE_MEM_DATA_O;
	assign MEM_C_DATA_BUS_OE = !port_en && CORE_MEM_DATA_OE;
	assign MEM_C_STROBES_N_O = CORE_MEM_STROBES_N;
	assign MEM_C_STROBES_N_OE = !port_en;
	assign CORE_MEM_DATA_I = MEM_C_DATA_BUS_I;
	assign MEM_C_OUTPUT_ENABLE_N_O = CORE_MEM_OE_N;
	assign MEM_C_OUTPUT_ENABLE_N_OE = !wide;
	assign AUX_ADDRESS_BIT_NINE_O = CORE_AUX_ADDR9;
	assign AUX_ADDRESS_BIT_NINE_OE = !wide;
	assign PANEL_BACKLIGHT_OUT_O = CORE_BACKLIGHT;
	assign PANEL_BACKLIGHT_OUT_OE = !wide;
	// Video data on the activity pin must not look like user activity.
	assign CORE_ACTIVITY = wide ? 1'b0 : ACTIVITY_INPUT;
	assign MEM_C_ADDRESS_BUS = wide ? pix_r[23:16] : CORE_MEM_ADDR;

	assign vid_pins = {ACTIVITY_INPUT, PANEL_BACKLIGHT_OUT_I, AUX_ADDRESS_BIT_NINE_I,
		MEM_C_OUTPUT_ENABLE_N_I, MEM_C_STROBES_N_I, MEM_C_DATA_BUS_I};
	assign narrow_pins = {MEM_C_STROBES_N_I[1:0], MEM_C_DATA_BUS_I};

	// An 18-bit pixel carries six bits per channel in the channel's top bits.
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			assign vid_pix[ch*vok_pkg::CHAN_W +: vok_pkg::CHAN_W] = wide ?
				vid_pins[ch*vok_pkg::CHAN_W +: vok_pkg::CHAN_W] :
				{narrow_pins[ch*vok_pkg::NARROW_CHAN_W +: vok_pkg::NARROW_CHAN_W], 2'b00};
		end
	endgenerate

	// The key travels with its pixel so both reach the mixer together.
	vok_fifo #(
		.W(vok_pkg::FIFO_W),
		.D(vok_pkg::FIFO_DEPTH)
	) u_fifo (
		.REF_CLK(REF_CLK),
		.RST(RST),
		.clr(!port_en),
		.in_valid(port_en && VIDEO_IN_STROBE),
		.in_ready(VIDEO_IN_READY),
		.in_data({EXT_COLOR_KEY, vid_pix}),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	// With the port on, each output pixel pairs one background and one video pixel.
	assign load = (ostate_r == vok_pkg::OS_EMPTY || OUT_READY) && (!port_en || fifo_valid);
	assign BG_READY = load;
	assign fifo_pop = load && BG_VALID && port_en;
	assign match = ext_key ? fifo_out[vok_pkg::KEY_BIT] :
		(((BG_PIXEL ^ cmp_val) & ~mask_val) == 24'h000000);
	assign take_video = port_en && match;

	always_comb begin
		ostate_nxt = ostate_r;
		pix_nxt = pix_r;
		if (load && BG_VALID) begin
			ostate_nxt = vok_pkg::OS_HELD;
			pix_nxt = take_video ? fifo_out[23:0] : BG_PIXEL;
		end else if (OUT_READY) begin
			ostate_nxt = vok_pkg::OS_EMPTY;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ostate_r <= vok_pkg::OS_EMPTY;
			pix_r <= 24'h000000;
		end else begin
			ostate_r <= ostate_nxt;
			pix_r <= pix_nxt;
		end
	end

	assign OUT_VALID = (ostate_r == vok_pkg::OS_HELD);
	assign OUT_PIXEL = pix_r;

	sequence s_bg_taken;
		BG_VALID && BG_READY;
	endsequence

	sequence s_ctrl_write(logic [7:0] v);
		IO_WR && IO_ADDR == vok_pkg::IO_DATA_ADDR && index_r == vok_pkg::IDX_CTRL &&
			IO_WDATA == v;
	endsequence

	AST_PINS_MEMORY_WHEN_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
		!port_en |-> MEM_C_STROBES_N_OE && MEM_C_DATA_BUS_OE == CORE_MEM_DATA_OE)
		else $error("Memory pins not driven with video port off.");
	AST_PINS_RELEASED_WHEN_ON: assert property (@(posedge REF_CLK) disable iff (RST)
		s_ctrl_write(8'h01) |=> !MEM_C_STROBES_N_OE && !MEM_C_DATA_BUS_OE)
		else $error("Memory pins still driven after port enable.");
	AST_WIDTH_SELECT: assert property (@(posedge REF_CLK) disable iff (RST)
		s_ctrl_write(8'h01) |=> !wide && MEM_C_OUTPUT_ENABLE_N_OE)
		else $error("Narrow port selected but wide pins released.");
	AST_WIDE_PINS_INPUT: assert property (@(posedge REF_CLK) disable iff (RST)
		s_ctrl_write(8'h03) |=> !MEM_C_OUTPUT_ENABLE_N_OE && !AUX_ADDRESS_BIT_NINE_OE &&
			!PANEL_BACKLIGHT_OUT_OE && !CORE_ACTIVITY)
		else $error("Wide mode did not release the four extra pins.");
	AST_WIDE_PANEL_HIGH: assert property (@(posedge REF_CLK) disable iff (RST)
		MEM_C_ADDRESS_BUS == ((regs_r[0][vok_pkg::CTRL_PORT_EN_BIT] &&
			regs_r[0][vok_pkg::CTRL_WIDE_BIT]) ? OUT_PIXEL[23:16] : CORE_MEM_ADDR))
		else $error("Address pins carry neither panel high byte nor memory address.");
	AST_EXT_KEY: assert property (@(posedge REF_CLK) disable iff (RST)
		s_bg_taken ##0 (port_en && ext_key && fifo_out[vok_pkg::KEY_BIT])
			|=> OUT_PIXEL == $past(fifo_out[23:0]))
		else $error("External key did not select the video pixel.");
	AST_CMP_READBACK: assert property (@(posedge REF_CLK) disable iff (RST)
		(IO_WR && IO_ADDR == vok_pkg::IO_DATA_ADDR && index_r == vok_pkg::IDX_CMP_MID)
			|=> cmp_val[15:8] == $past(IO_WDATA))
		else $error("Compare middle byte not stored.");
	AST_KEY_MATCH: assert property (@(posedge REF_CLK) disable iff (RST)
		s_bg_taken ##0 (port_en && !ext_key && ((BG_PIXEL ^ cmp_val) & ~mask_val) == 24'h0)
			|=> OUT_PIXEL == $past(fifo_out[23:0]))
		else $error("Key match did not show the video pixel.");
	AST_MASK_EXCLUDES: assert property (@(posedge REF_CLK) disable iff (RST)
		s_bg_taken ##0 (port_en && !ext_key && ((BG_PIXEL ^ cmp_val) & ~mask_val) != 24'h0)
			|=> OUT_PIXEL == $past(BG_PIXEL))
		else $error("Unmasked mismatch still replaced the background.");
	AST_MASK_HIGH_BYTE: assert property (@(posedge REF_CLK) disable iff (RST)
		(IO_WR && IO_ADDR == vok_pkg::IO_DATA_ADDR && index_r == vok_pkg::IDX_MASK_HI)
			|=> mask_val[23:16] == $past(IO_WDATA))
		else $error("Mask high byte not stored.");
	AST_PASS_WHEN_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
		s_bg_taken ##0 !port_en |=> OUT_VALID && OUT_PIXEL == $past(BG_PIXEL))
		else $error("Background not passed with port off.");
endmodule // vok_overlay

// *** test/vok_vsrc.sv ***
// Behavioural external video source driving the shared memory-channel pins.
`timescale 1ns/1ns
module vok_vsrc (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [23:0] pix,
	input wire logic key,
	input wire logic ready,
	output logic stb,
	output logic ckey,
	output logic [23:0] pins
);
	initial begin
		stb = 1'b0;
		ckey = 1'b0;
		pins = 24'h000000;
	end
	// Released lines show the inverse of the last pixel, so a stale sample never looks fresh.
	always @(posedge ref_clk) begin
		if (stb && ready) begin
			stb <= 1'b0;
			pins <= ~pins;
			ckey <= ~ckey;
		end else if (go && !stb) begin
			stb <= 1'b1;
			pins <= pix;
			ckey <= key;
		end
	end
endmodule // vok_vsrc

// *** test/tb_top.sv ***
// Self-checking bench for the video overlay color key block.
`timescale 1ns/1ns
module tb_top;
	logic clk, rst, io_wr, io_rd, go, key, core_oe, bg_valid, out_ready, wide, act;
	logic mdoe, soe, oeo, oeoe, a9o, a9oe, blo, bloe, vs_stb, vs_key, in_rdy, bg_rdy, out_valid;
	logic [15:0] io_addr, mdo, cmdi;
	logic [7:0] io_wdata, io_rdata, core_addr, addr_bus;
	logic [3:0] so;
	logic [23:0] pix, bg_pixel, out_pixel, vp, exp18;
	logic [23:0] p18 = 24'hfeb3c7;
	logic [23:0] rows [9] = '{24'hd9ff07, 24'hda1111, 24'hdb2222, 24'hdc3333, 24'hdd4444,
		24'hde5555, 24'hdf6666, 24'hd87700, 24'he08800};
	int n_fail, n_tests, i;
	vok_vsrc i_src (.ref_clk(clk), .go(go), .pix(pix), .key(key), .ready(in_rdy), .stb(vs_stb),
		.ckey(vs_key), .pins(vp));
	vok_overlay i_dut (.REF_CLK(clk), .RST(rst), .IO_WR(io_wr), .IO_RD(io_rd), .IO_ADDR(io_addr),
		.IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .MEM_C_DATA_BUS_I(mdoe ? mdo : vp[15:0]),
		.MEM_C_DATA_BUS_O(mdo), .MEM_C_DATA_BUS_OE(mdoe), .MEM_C_STROBES_N_I(soe ? so : vp[19:16]),
		.MEM_C_STROBES_N_O(so), .MEM_C_STROBES_N_OE(soe),
		.MEM_C_OUTPUT_ENABLE_N_I(oeoe ? oeo : vp[20]), .MEM_C_OUTPUT_ENABLE_N_O(oeo),
		.MEM_C_OUTPUT_ENABLE_N_OE(oeoe), .AUX_ADDRESS_BIT_NINE_I(a9oe ? a9o : vp[21]),
		.AUX_ADDRESS_BIT_NINE_O(a9o), .AUX_ADDRESS_BIT_NINE_OE(a9oe),
		.PANEL_BACKLIGHT_OUT_I(bloe ? blo : vp[22]), .PANEL_BACKLIGHT_OUT_O(blo),
		.PANEL_BACKLIGHT_OUT_OE(bloe), .ACTIVITY_INPUT(vp[23]), .MEM_C_ADDRESS_BUS(addr_bus),
		.EXT_COLOR_KEY(vs_key), .VIDEO_IN_STROBE(vs_stb), .VIDEO_IN_READY(in_rdy),
		.CORE_MEM_DATA_O(16'ha5c3), .CORE_MEM_DATA_OE(core_oe), .CORE_MEM_DATA_I(cmdi),
		.CORE_MEM_STROBES_N(4'hf), .CORE_MEM_OE_N(1'b1), .CORE_AUX_ADDR9(1'b0),
		.CORE_BACKLIGHT(1'b1), .CORE_MEM_ADDR(core_addr), .CORE_ACTIVITY(act),
		.BG_VALID(bg_valid), .BG_READY(bg_rdy), .BG_PIXEL(bg_pixel), .OUT_VALID(out_valid),
		.OUT_READY(out_ready), .OUT_PIXEL(out_pixel));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		n_tests++;
		if (got !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	// A wait that runs out of bound is scored as a mismatch and ends the run.
	task automatic bail();
		chk(32'h0, 32'h1);
		complete_run();
	endtask
	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		io_wr <= w;
		io_rd <= !w;
		io_addr <= a;
		io_wdata <= d;
		@(posedge clk);
		io_wr <= 1'b0;
		io_rd <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] x, input logic [7:0] v);
		io(1'b1, vok_pkg::IO_INDEX_ADDR, x);
		io(1'b1, vok_pkg::IO_DATA_ADDR, v);
	endtask
	task automatic rd(input logic [7:0] x, input logic [7:0] e);
		io(1'b1, vok_pkg::IO_INDEX_ADDR, x);
		io(1'b0, vok_pkg::IO_DATA_ADDR, 8'h00);
		#1;
		chk({24'h0, io_rdata}, {24'h0, e});
	endtask
	task automatic vid(input logic [23:0] p, input logic k);
		int c;
		@(posedge clk);
		go <= 1'b1;
		pix <= p;
		key <= k;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (c = 0; vs_stb; c++) begin
			if (c == 20) bail();
			@(posedge clk);
			#1;
		end
	endtask
	task automatic px(input logic [23:0] b, input logic [23:0] e);
		int c;
		@(posedge clk);
		bg_valid <= 1'b1;
		bg_pixel <= b;
		#1;
		for (c = 0; !bg_rdy; c++) begin
			if (c == 20) bail();
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		bg_valid <= 1'b0;
		#1;
		chk({7'h0, out_valid, out_pixel}, {8'h01, e});
		chk({24'h0, addr_bus}, {24'h0, wide ? e[23:16] : core_addr});
	endtask
	initial begin
		rst = 1'b1;
		{io_wr, io_rd, go, key, bg_valid, wide} = 6'h00;
		{core_oe, out_ready} = 2'h3;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		pix = 24'h000000;
		bg_pixel = 24'h000000;
		core_addr = 8'h3c;
		n_fail = 0;
		n_tests = 0;
		exp18 = {p18[17:12], 2'b00, p18[11:6], 2'b00, p18[5:0], 2'b00};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 7; i++) rd(8'hd9 + 8'(i), 8'h00);
		for (i = 0; i < 9; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		// The index port reads back the last index written.
		io(1'b0, vok_pkg::IO_INDEX_ADDR, 8'h00);
		#1;
		chk({24'h0, io_rdata}, 32'h000000e0);
		wr(8'hd9, 8'h00);
		#1;
		chk({13'h0, act, mdoe, soe, mdo}, {13'h0, vp[23], 2'b11, 16'ha5c3});
		chk({9'h0, so, oeo, a9o, blo, cmdi}, {9'h0, 4'hf, 3'b101, 16'ha5c3});
		px(24'h123456, 24'h123456);
		wr(8'hda, 8'h56);
		wr(8'hdb, 8'h34);
		wr(8'hdc, 8'h12);
		wr(8'hdd, 8'h0f);
		wr(8'hde, 8'h00);
		wr(8'hdf, 8'h80);
		// Configuration bit 6 is taken as clear, so wide mode is allowed here.
		wr(8'hd9, 8'h03);
		wide = 1'b1;
		#1;
		chk({26'h0, mdoe, soe, oeoe, a9oe, bloe, act}, 32'h0);
		vid(24'habcdef, 1'b0);
		px(24'h92345a, 24'habcdef);
		vid(24'h654321, 1'b0);
		px(24'h12355a, 24'h12355a);
		wr(8'hd9, 8'h01);
		wide = 1'b0;
		#1;
		// The released lines stand high on the activity bit here, so a forced zero would show.
		chk({12'h0, act, oeoe, a9oe, soe, cmdi}, {12'h0, vp[23], 3'b110, vp[15:0]});
		vid(p18, 1'b0);
		px(24'h123450, exp18);
		wr(8'hd9, 8'h05);
		vid(p18, 1'b1);
		px(24'h000000, exp18);
		vid(24'h000000, 1'b0);
		px(24'h123450, 24'h123450);
		wr(8'hd9, 8'h03);
		wide = 1'b1;
		#1;
		chk({31'h0, act}, 32'h0);
		for (i = 0; i < 8; i++) vid(24'h010101 * 24'(i), 1'b0);
		@(posedge clk);
		go <= 1'b1;
		pix <= 24'hffffff;
		@(posedge clk);
		go <= 1'b0;
		out_ready <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({30'h0, in_rdy, vs_stb}, 32'h1);
		for (i = 0; i < 9; i++) begin
			px(24'h92345a, i < 8 ? 24'h010101 * 24'(i) : 24'hffffff);
			if (i == 0) begin
				repeat (2) @(posedge clk);
				#1;
				chk({7'h0, out_valid, out_pixel}, 32'h01000000);
				@(posedge clk);
				out_ready <= 1'b1;
			end
		end
		// Leave a pixel held at the output so the mid-run reset has something to clear.
		vid(24'h0a0b0c, 1'b0);
		@(posedge clk);
		out_ready <= 1'b0;
		px(24'h000000, 24'h000000);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({22'h0, out_valid, in_rdy, addr_bus}, {22'h0, 2'b01, core_addr});
		rd(8'hd9, 8'h00);
		chk({31'h0, soe}, 32'h1);
		rd(8'hda, 8'h00);
		complete_run();
	end
endmodule // tb_top
